/* core/serial_port_baud_and_shift.sv */
//----------------------------------------------------------------------------
// Purpose: serial port baud sources and shift engines, AXI4-Lite registers
// Assumes: mclk is the oscillator; sys_rst synchronous, active high
// Notes:   one packed state struct, filled by one comb process
// Operation
// - shift mode clocks bits at oscillator divided by twelve
// - fixed nine-bit mode runs at osc/64, or osc/32 with doubler
// - timer 1 rate times two-to-doubler over thirty-two
// - tx/rx source selects pick timer 2 per direction independently
// - timer 2 high byte overflow reloads both bytes from reload pair
// - with timer 2 as source, baud is overflow rate over sixteen
// - timer 2 as baud generator counts every state time
// - baud overflow sets no flag; ext pin edge sets event, no reload
// - shift mode moves eight bits LSB first, clock on transmit pin
// - buffer write loads marker one, transmit active from the next S6P2
// - shift clock low S3 to S5, high S6 to S2
// - transmit shifts right at S6P2, last shift, done at S1P1
// - receive starts on enable and clear flag, loads 11111110
// - receive shifts left at S6P2 with pin sampled at S5P2
// - zero at left ends reception, loads buffer, flag at S1P1
// - async frame: start zero, eight data LSB first, ninth bit in nine-bit modes, stop one
// - async transmit starts after next divide-by-16 rollover
// - receiver samples at 16x, falling edge resets counter, 1FFH
// - bit is majority of counter states 7, 8, 9; bad start resets
// - start bit in bit 0 triggers final shift and load
// - load only if done flag clear and filter off or bit one
//----------------------------------------------------------------------------
`timescale 1ns/100ps
`include "serial_port_consts.svh"

module serial_port_baud_and_shift
  import serial_port_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic txd,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  input wire logic ext_trigger_pin
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic wlane;
    logic aw_got;
    logic w_got;
    logic [7:0] serial_control;
    logic [7:0] serial_buffer;
    logic [7:0] power_control;
    logic [7:0] timer_mode_reg;
    logic [7:0] baud_timer_reload;
    logic [7:0] t1_count;
    logic [7:0] aux_timer_control;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic [7:0] aux_count_low;
    logic [7:0] aux_count_high;
    logic [3:0] phase;
    logic [1:0] m2_div;
    logic t1_half;
    logic t2_half;
    logic [1:0] rxd_sync;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic m0_sample;
    logic tx_req;
    logic tx_send;
    logic tx_last;
    logic [10:0] tx_sh;
    logic [3:0] tx_div;
    logic [3:0] tx_bits;
    logic txd;
    rx_state_t rx_state;
    logic [3:0] rx_div;
    logic [8:0] rx_sh;
    logic [1:0] votes;
    logic rx_prev;
    logic rx_last;
    logic rxd_out;
    logic rxd_oe;
  } state_t;

  state_t s;
  state_t next_s;

  //--------------------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------------------
  // mapped register offsets, shared by read and write decode
  function automatic logic reg_known(input logic [5:0] a);
    case (a)
      `OFF_SERIAL_CONTROL, `OFF_SERIAL_BUFFER, `OFF_POWER_CONTROL,
      `OFF_TIMER_MODE, `OFF_BAUD_RELOAD, `OFF_AUX_CONTROL,
      `OFF_RELOAD_LOW, `OFF_RELOAD_HIGH, `OFF_AUX_COUNT_LOW,
      `OFF_AUX_COUNT_HIGH: reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  endfunction : reg_known

  // shift mode collects MSB-side first; flip back to byte order
  function automatic logic [7:0] flip8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      flip8[i] = v[7 - i];
    end
  endfunction : flip8

  //--------------------------------------------------------------------------
  // next-state logic
  //--------------------------------------------------------------------------
  always_comb begin
    logic [1:0] mode;
    logic doubler;
    logic s6p2;
    logic t1_ovf;
    logic t1_tick;
    logic t2_ovf;
    logic baud_gen;
    logic m2_tick;
    logic tx_tick;
    logic rx_tick;
    logic tx_roll;
    logic bit_val;
    logic [15:0] t2_val;
    logic [8:0] rx_new;
    logic ninth;
    logic [3:0] frame_len;
    mode = 2'h0;
    doubler = 1'b0;
    s6p2 = 1'b0;
    t1_ovf = 1'b0;
    t1_tick = 1'b0;
    t2_ovf = 1'b0;
    baud_gen = 1'b0;
    m2_tick = 1'b0;
    tx_tick = 1'b0;
    rx_tick = 1'b0;
    tx_roll = 1'b0;
    bit_val = 1'b0;
    t2_val = 16'h0000;
    rx_new = 9'h000;
    ninth = 1'b0;
    frame_len = 4'h0;
    next_s = s;
    mode = s.serial_control[7:6];
    doubler = s.power_control[`PC_DOUBLER];
    s6p2 = (s.phase == `PH_S6P2);
    baud_gen = s.aux_timer_control[`AC_TX_SEL]
             | s.aux_timer_control[`AC_RX_SEL];

    // pin synchronisers; only the second stage is read
    next_s.rxd_sync = {s.rxd_sync[0], rxd_in};
    next_s.ext_sync = {s.ext_sync[0], ext_trigger_pin};
    next_s.ext_prev = s.ext_sync[1];

    // machine cycle of twelve oscillator phases
    next_s.phase = s6p2 ? `PH_S1P1 : s.phase + 4'h1;

    // ---- AXI4-Lite write channel --------------------------------------
    if (s_axi_awvalid && s.awready) begin
      next_s.waddr = s_axi_awaddr;
      next_s.aw_got = 1'b1;
      next_s.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wlane = s_axi_wstrb[0];
      next_s.w_got = 1'b1;
      next_s.wready = 1'b0;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (s.aw_got && s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = reg_known(s.waddr) ? `AXI_OKAY : `AXI_SLVERR;
      if (s.wlane) begin
        case (s.waddr)
          `OFF_SERIAL_CONTROL: next_s.serial_control = s.wdata;
          `OFF_POWER_CONTROL: next_s.power_control = s.wdata;
          `OFF_TIMER_MODE: next_s.timer_mode_reg = s.wdata;
          `OFF_BAUD_RELOAD: next_s.baud_timer_reload = s.wdata;
          `OFF_AUX_CONTROL: next_s.aux_timer_control = s.wdata;
          `OFF_RELOAD_LOW: next_s.reload_low = s.wdata;
          `OFF_RELOAD_HIGH: next_s.reload_high = s.wdata;
          `OFF_AUX_COUNT_LOW: next_s.aux_count_low = s.wdata;
          `OFF_AUX_COUNT_HIGH: next_s.aux_count_high = s.wdata;
          `OFF_SERIAL_BUFFER: begin
            // a write ignored while a frame is still going out
            if (!s.tx_send && !s.tx_req) begin
              next_s.tx_req = 1'b1;
              next_s.tx_bits = 4'h0;
              if (mode == MODE_SHIFT) begin
                next_s.tx_sh = {2'b00, 1'b1, s.wdata};
              end else begin
                ninth = (mode == MODE_UART8) ? 1'b1
                      : s.serial_control[`SC_TX_NINTH];
                next_s.tx_sh = {1'b1, ninth, s.wdata, 1'b0};
              end
            end
          end
          default: ;
        endcase
      end
    end

    // ---- AXI4-Lite read channel ---------------------------------------
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = reg_known(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
      next_s.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `OFF_SERIAL_CONTROL: next_s.rdata[7:0] = s.serial_control;
        `OFF_SERIAL_BUFFER: next_s.rdata[7:0] = s.serial_buffer;
        `OFF_POWER_CONTROL: next_s.rdata[7:0] = s.power_control;
        `OFF_TIMER_MODE: next_s.rdata[7:0] = s.timer_mode_reg;
        `OFF_BAUD_RELOAD: next_s.rdata[7:0] = s.baud_timer_reload;
        `OFF_AUX_CONTROL: next_s.rdata[7:0] = s.aux_timer_control;
        `OFF_RELOAD_LOW: next_s.rdata[7:0] = s.reload_low;
        `OFF_RELOAD_HIGH: next_s.rdata[7:0] = s.reload_high;
        `OFF_AUX_COUNT_LOW: next_s.rdata[7:0] = s.aux_count_low;
        `OFF_AUX_COUNT_HIGH: next_s.rdata[7:0] = s.aux_count_high;
        default: ;
      endcase
    end

    // ---- timer 1: 8-bit auto-reload, one count per machine cycle -------
    // runs only when configured for auto-reload; it raises no interrupt
    if (s6p2 && s.timer_mode_reg[7:4] == `T1_AUTO_RELOAD) begin
      if (s.t1_count == 8'hFF) begin
        next_s.t1_count = s.baud_timer_reload;
        t1_ovf = 1'b1;
      end else begin
        next_s.t1_count = s.t1_count + 8'h01;
      end
    end
    // every overflow with doubler, else every second one
    if (t1_ovf) begin
      next_s.t1_half = ~s.t1_half;
    end
    t1_tick = t1_ovf && (doubler || s.t1_half);

    // ---- timer 2 -------------------------------------------------------
    t2_val = {s.aux_count_high, s.aux_count_low};
    next_s.t2_half = ~s.t2_half;
    if (s.aux_timer_control[`AC_RUN]) begin
      // baud generator counts per state time, plain mode per cycle
      if (baud_gen ? s.t2_half : s6p2) begin
        if (t2_val == 16'hFFFF) begin
          next_s.aux_count_high = s.reload_high;
          next_s.aux_count_low = s.reload_low;
          t2_ovf = baud_gen;
          if (!baud_gen) begin
            next_s.aux_timer_control[`AC_OVF] = 1'b1;
          end
        end else begin
          t2_val = t2_val + 16'h0001;
          next_s.aux_count_high = t2_val[15:8];
          next_s.aux_count_low = t2_val[7:0];
        end
      end
    end
    // falling edge on the trigger pin; reload only outside baud mode
    if (s.ext_prev && !s.ext_sync[1]
        && s.aux_timer_control[`AC_EXT_EN]) begin
      next_s.aux_timer_control[`AC_EXT_EVENT] = 1'b1;
      if (!baud_gen) begin
        next_s.aux_count_high = s.reload_high;
        next_s.aux_count_low = s.reload_low;
      end
    end

    // ---- 16x ticks per direction ---------------------------------------
    next_s.m2_div = s.m2_div + 2'h1;
    m2_tick = (s.m2_div & (doubler ? `M2_DIV_FAST : `M2_DIV_SLOW)) == 2'h0;
    if (mode == MODE_FIXED9) begin
      tx_tick = m2_tick;
      rx_tick = m2_tick;
    end else begin
      // timer 2 overflow is used directly: 16 per bit time
      tx_tick = s.aux_timer_control[`AC_TX_SEL] ? t2_ovf : t1_tick;
      rx_tick = s.aux_timer_control[`AC_RX_SEL] ? t2_ovf : t1_tick;
    end
    if (tx_tick) begin
      next_s.tx_div = s.tx_div + 4'h1;
    end
    tx_roll = tx_tick && s.tx_div == `DIV16_LAST;
    frame_len = (mode == MODE_UART8) ? 4'h9 : 4'hA;

    // ---- transmitter ---------------------------------------------------
    if (mode == MODE_SHIFT) begin
      // active from the next S6P2 after the write, 1 to 12 clocks later
      if (s6p2 && s.tx_req) begin
        next_s.tx_req = 1'b0;
        next_s.tx_send = 1'b1;
      end
      if (s6p2 && s.tx_send) begin
        next_s.tx_sh = {1'b0, s.tx_sh[10:1]};
        if (s.tx_sh[8:2] == 7'h00) begin
          next_s.tx_last = 1'b1;
        end
      end
      if (s.phase == `PH_S1P1 && s.tx_last) begin
        next_s.tx_last = 1'b0;
        next_s.tx_send = 1'b0;
        next_s.serial_control[`SC_TX_DONE] = 1'b1;
      end
    end else if (tx_roll) begin
      // bit times follow the divide-by-16 counter, not the write
      if (s.tx_req) begin
        next_s.tx_req = 1'b0;
        next_s.tx_send = 1'b1;
      end else if (s.tx_send) begin
        next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
        next_s.tx_bits = s.tx_bits + 4'h1;
        // stop bit now on the line: finish and flag
        if (s.tx_bits + 4'h1 == frame_len) begin
          next_s.tx_send = 1'b0;
          next_s.serial_control[`SC_TX_DONE] = 1'b1;
        end
      end
    end

    // ---- receiver ------------------------------------------------------
    if (s.phase == `PH_S5P2) begin
      next_s.m0_sample = s.rxd_sync[1];
    end
    if (rx_tick) begin
      next_s.rx_prev = s.rxd_sync[1];
    end
    unique case (s.rx_state)
      RX_HUNT: begin
        if (s.serial_control[`SC_RX_EN]) begin
          if (mode == MODE_SHIFT) begin
            if (!s.serial_control[`SC_RX_DONE]) begin
              next_s.rx_state = RX_M0_ARM;
            end
          end else if (rx_tick && s.rx_prev && !s.rxd_sync[1]) begin
            next_s.rx_div = 4'h0;
            next_s.rx_sh = `RX_PRELOAD;
            next_s.rx_state = RX_FRAME;
          end
        end
      end
      RX_M0_ARM: begin
        if (s6p2) begin
          next_s.rx_sh = {1'b0, `M0_RX_PRELOAD};
          next_s.rx_state = RX_M0_RUN;
        end
      end
      RX_M0_RUN: begin
        if (s6p2 && !s.rx_last) begin
          rx_new = {1'b0, s.rx_sh[6:0], s.m0_sample};
          next_s.rx_sh = rx_new;
          if (!s.rx_sh[7]) begin
            next_s.serial_buffer = flip8(rx_new[7:0]);
            next_s.rx_last = 1'b1;
          end
        end
        if (s.phase == `PH_S1P1 && s.rx_last) begin
          next_s.rx_last = 1'b0;
          next_s.serial_control[`SC_RX_DONE] = 1'b1;
          next_s.rx_state = RX_HUNT;
        end
      end
      RX_FRAME: begin
        if (rx_tick) begin
          next_s.rx_div = s.rx_div + 4'h1;
          if (s.rx_div >= `VOTE_FIRST && s.rx_div < `VOTE_LAST) begin
            next_s.votes = {s.votes[0], s.rxd_sync[1]};
          end
          if (s.rx_div == `VOTE_LAST) begin
            // two of three samples; rejects a noise spike
            bit_val = (s.votes[0] & s.votes[1])
                    | (s.votes[0] & s.rxd_sync[1])
                    | (s.votes[1] & s.rxd_sync[1]);
            rx_new = {bit_val, s.rx_sh[8:1]};
            next_s.rx_sh = rx_new;
            if (s.rx_sh == `RX_PRELOAD && bit_val) begin
              next_s.rx_state = RX_HUNT;
            end else if (!s.rx_sh[0]) begin
              // start bit was in bit 0: this was the last shift
              next_s.rx_state = RX_HUNT;
              if (!s.serial_control[`SC_RX_DONE]
                  && (!s.serial_control[`SC_FILTER] || rx_new[8])) begin
                next_s.serial_buffer = rx_new[7:0];
                next_s.serial_control[`SC_RX_NINTH] = rx_new[8];
                next_s.serial_control[`SC_RX_DONE] = 1'b1;
              end
            end
          end
        end
      end
    endcase

    // ---- pins ----------------------------------------------------------
    // data on the receive pin, shift clock on the transmit pin
    if (mode == MODE_SHIFT) begin
      next_s.txd = !(next_s.tx_send || next_s.rx_state == RX_M0_RUN)
                 || next_s.phase < `PH_S3P1
                 || next_s.phase >= `PH_S6P1;
      next_s.rxd_out = next_s.tx_sh[0];
      next_s.rxd_oe = next_s.tx_send;
    end else begin
      next_s.txd = next_s.tx_send ? next_s.tx_sh[0] : 1'b1;
      next_s.rxd_out = 1'b1;
      next_s.rxd_oe = 1'b0;
    end
  end

  //--------------------------------------------------------------------------
  // state register
  //--------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.rx_state <= RX_HUNT;
      s.rx_sh <= `RX_PRELOAD;
      s.rxd_sync <= 2'b11;
      s.ext_sync <= 2'b11;
      s.ext_prev <= 1'b1;
      s.rx_prev <= 1'b1;
      s.txd <= 1'b1;
      s.rxd_out <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flip-flops
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign txd = s.txd;
  assign rxd_out = s.rxd_out;
  assign rxd_oe = s.rxd_oe;

endmodule : serial_port_baud_and_shift

/* include/serial_port_consts.svh */
//----------------------------------------------------------------------------
// Purpose: offsets, field positions and timing counts of the serial port
// Assumes: 32-bit AXI4-Lite, one register per aligned word
// Notes:   definitions only
//----------------------------------------------------------------------------
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// register byte offsets
`define OFF_SERIAL_CONTROL 6'h00
`define OFF_SERIAL_BUFFER 6'h04
`define OFF_POWER_CONTROL 6'h08
`define OFF_TIMER_MODE 6'h0C
`define OFF_BAUD_RELOAD 6'h10
`define OFF_AUX_CONTROL 6'h14
`define OFF_RELOAD_LOW 6'h18
`define OFF_RELOAD_HIGH 6'h1C
`define OFF_AUX_COUNT_LOW 6'h20
`define OFF_AUX_COUNT_HIGH 6'h24

// serial_control fields
`define SC_FILTER 5
`define SC_RX_EN 4
`define SC_TX_NINTH 3
`define SC_RX_NINTH 2
`define SC_TX_DONE 1
`define SC_RX_DONE 0
// power_control field
`define PC_DOUBLER 7
// aux_timer_control fields
`define AC_OVF 7
`define AC_EXT_EVENT 6
`define AC_RX_SEL 5
`define AC_TX_SEL 4
`define AC_EXT_EN 3
`define AC_RUN 2

// timer 1 upper nibble for 8-bit auto-reload
`define T1_AUTO_RELOAD 4'h2
// oscillator phases inside one machine cycle (S1P1 = 0 .. S6P2 = 11)
`define PH_S1P1 4'h0
`define PH_S3P1 4'h4
`define PH_S5P2 4'h9
`define PH_S6P1 4'hA
`define PH_S6P2 4'hB
// fixed-rate 16x tick: every 4 clocks (1/64) or 2 clocks (1/32)
`define M2_DIV_SLOW 2'h3
`define M2_DIV_FAST 2'h1
`define DIV16_LAST 4'hF
`define VOTE_FIRST 4'h7
`define VOTE_LAST 4'h9
`define M0_RX_PRELOAD 8'hFE
`define RX_PRELOAD 9'h1FF
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

/* include/serial_port_pkg.sv */
//----------------------------------------------------------------------------
// Purpose: types of the serial port
// Assumes: constants live in serial_port_consts.svh
// Notes:   receiver states are one-hot
//----------------------------------------------------------------------------
package serial_port_pkg;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_UART8 = 2'h1,
    MODE_FIXED9 = 2'h2,
    MODE_VAR9 = 2'h3
  } mode_t;

  typedef enum logic [3:0] {
    RX_HUNT = 4'b0001,
    RX_FRAME = 4'b0010,
    RX_M0_ARM = 4'b0100,
    RX_M0_RUN = 4'b1000
  } rx_state_t;

endpackage : serial_port_pkg

/* verification/serial_peer.sv */
// Purpose: remote async serial peer driving the receive pin
// Assumes: bit time given in mclk cycles per call
// Notes:   line rests at mark (1) between frames
`timescale 1ns/100ps
module serial_peer (
  input wire logic mclk,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  output logic rxd_in
);
  logic drv = 1'b1;
  // pin level: the device wins while it drives, the peer otherwise
  assign rxd_in = rxd_oe ? rxd_out : drv;
  // one frame: start low, eight data LSB first, stop high
  task automatic send(input logic [7:0] d, input int per);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drv <= f[i];
      repeat (per) @(posedge mclk);
    end
  endtask : send
endmodule : serial_peer

/* verification/serial_port_chk.sv */
// Purpose: port-level checks of the serial port block
// Assumes: one clock domain, mclk; sys_rst synchronous, active high
// Notes:   sees only the top ports, bound in below the module
`timescale 1ns/100ps
module serial_port_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic txd,
  input wire logic rxd_out,
  input wire logic rxd_oe
);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // read answers arrive one edge after the request is taken, write answers two
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid) else $error("wr late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("rd late");
  // answers stand until the master takes them
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  rd_upper_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h00_0000) else $error("upper bits set");
  // no second request while one is answered
  wr_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("wr not blocked");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("rd not blocked");
  // shift clock: six phases low, then high; 12 phases per bit
  shclk_low_a: assert property ($rose(txd) && rxd_oe |->
    $past(txd, 7) && !$past(txd, 6) && !$past(txd, 3))
    else $error("shift clock shape");
  // data moves only while the shift clock is high
  shift_edge_a: assert property ($changed(rxd_out) && rxd_oe &&
    $past(rxd_oe) |-> txd && $past(txd)) else $error("shift edge");
  cover property ($rose(rxd_oe));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($fell(txd) && !rxd_oe);
endmodule : serial_port_chk
bind serial_port_baud_and_shift serial_port_chk CHK (.*);

/* verification/tb_top.sv */
// Purpose: register-level tests of the serial port with a serial peer
// Assumes: 10 MHz mclk, AXI4-Lite master in this bench
// Notes:   every wait is bounded; a spent bound ends the run
`timescale 1ns/100ps
`include "serial_port_consts.svh"
module tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_trigger_pin = 1'b1;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic [5:0] s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, txd, rxd_in, rxd_out, rxd_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, val;
  logic [15:0] cv;
  int errors = 0, compares = 0;
  serial_port_baud_and_shift DUT (.*);
  serial_peer PEER (.*);
  // free-running oscillator, 100 ns period
  initial forever #50 mclk = ~mclk;
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task print_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic hang;
    errors++;
    print_verdict();
  endtask : hang
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      errors++;
    end
  endtask : chk
  task automatic endt(input string s);
    $display("test %s finished, errors=%0d", s, errors);
  endtask : endt
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] r = `AXI_OKAY);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (50) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(r));
        return;
      end
    end
    hang();
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    input logic [1:0] r = `AXI_OKAY);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (50) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk(32'(s_axi_rresp), 32'(r));
        return;
      end
    end
    hang();
  endtask : rd
  // poll one serial_control flag until hardware sets it
  task automatic poll(input int b);
    logic [31:0] v;
    repeat (300) begin
      rd(`OFF_SERIAL_CONTROL, v);
      if (v[b] === 1'b1) return;
    end
    hang();
  endtask : poll
  // wait for txd (s=0) or rxd_oe (s=1) to reach a level
  task automatic wpin(input bit s, input logic lv);
    repeat (6000) begin
      if ((s ? rxd_oe : txd) === lv) return;
      @(posedge mclk);
    end
    hang();
  endtask : wpin
  // sample an async frame at mid-bit, start bit into bit 0
  task automatic cap(input int nb, input int per, output logic [15:0] v);
    v = 16'h0000;
    wpin(1'b0, 1'b0);
    repeat (per / 2) @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      v[i] = txd;
      repeat (per) @(posedge mclk);
    end
  endtask : cap
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(`OFF_POWER_CONTROL, val);
    chk(val, 32'h0000_0000);
    rd(6'h28, val, `AXI_SLVERR);
    chk(val, 32'h0000_0000);
    wr(6'h28, 8'hFF, `AXI_SLVERR);
    endt("reset");
    // shift mode: capture data at each rising shift clock
    wr(`OFF_SERIAL_BUFFER, 8'hA5);
    wpin(1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wpin(1'b0, 1'b0);
      wpin(1'b0, 1'b1);
      cv[i] = rxd_out;
    end
    chk(32'(cv[7:0]), 32'h0000_00A5);
    poll(`SC_TX_DONE);
    endt("shift_tx");
    // timer 1 in 8-bit reload, doubler on: 192 clocks a bit
    wr(`OFF_TIMER_MODE, 8'h20);
    wr(`OFF_BAUD_RELOAD, 8'hFF);
    wr(`OFF_POWER_CONTROL, 8'h80);
    wr(`OFF_SERIAL_CONTROL, 8'h50);
    wr(`OFF_SERIAL_BUFFER, 8'h3C);
    cap(10, 192, cv);
    chk(32'(cv), 32'h0000_0278);
    poll(`SC_TX_DONE);
    PEER.send(8'h5A, 192);
    poll(`SC_RX_DONE);
    rd(`OFF_SERIAL_BUFFER, val);
    chk(val, 32'h0000_005A);
    rd(`OFF_SERIAL_CONTROL, val);
    chk(val, 32'h0000_0057);
    // second frame while the done flag still stands is lost
    PEER.send(8'hC3, 192);
    rd(`OFF_SERIAL_BUFFER, val);
    chk(val, 32'h0000_005A);
    endt("uart_timer1");
    // timer 2 for receive only, 3 states a tick: 96 clocks a bit
    wr(`OFF_SERIAL_CONTROL, 8'h50);
    wr(`OFF_RELOAD_LOW, 8'hFD);
    wr(`OFF_RELOAD_HIGH, 8'hFF);
    wr(`OFF_AUX_COUNT_LOW, 8'hFD);
    wr(`OFF_AUX_COUNT_HIGH, 8'hFF);
    wr(`OFF_AUX_CONTROL, 8'h2C);
    PEER.send(8'h96, 96);
    poll(`SC_RX_DONE);
    rd(`OFF_SERIAL_BUFFER, val);
    chk(val, 32'h0000_0096);
    ext_trigger_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    ext_trigger_pin <= 1'b1;
    rd(`OFF_AUX_CONTROL, val);
    chk(val, 32'h0000_006C);
    endt("uart_timer2");
    // fixed nine-bit mode, doubler off: 64 clocks a bit
    wr(`OFF_AUX_CONTROL, 8'h00);
    wr(`OFF_POWER_CONTROL, 8'h00);
    wr(`OFF_SERIAL_CONTROL, 8'h88);
    wr(`OFF_SERIAL_BUFFER, 8'h55);
    cap(11, 64, cv);
    chk(32'(cv), 32'h0000_06AA);
    endt("fixed_nine");
    wr(`OFF_SERIAL_CONTROL, 8'h10);
    poll(`SC_RX_DONE);
    rd(`OFF_SERIAL_BUFFER, val);
    chk(val, 32'h0000_00FF);
    endt("shift_rx");
    print_verdict();
  end
endmodule : tb_top
